// file: design/rrs_cfg.svh
/*
 * Constants for the return/rotate/sleep execution block: register offsets,
 * field positions, operation codes, widths and reset values.
 * Assumes it is included by bare name after `default_nettype none.
 */
`ifndef RRS_CFG_SVH
`define RRS_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses, one 32-bit word each)
`define RRS_ADDR_W 6
`define RRS_OFF_CMD 6'h00
`define RRS_OFF_WREG 6'h04
`define RRS_OFF_STATUS 6'h08
`define RRS_OFF_PC 6'h0c
`define RRS_OFF_STACK 6'h10
`define RRS_OFF_WDOG 6'h14
`define RRS_OFF_FADDR 6'h18
`define RRS_OFF_FDATA 6'h1c
`define RRS_OFF_WAKE 6'h20

// ==========================================================================
// Command word fields
`define RRS_OP_LSB 0
`define RRS_OP_MSB 2
`define RRS_DEST_BIT 7
`define RRS_FA_LSB 8
`define RRS_FA_MSB 14
`define RRS_OP_NOP 3'h0
`define RRS_OP_RETURN 3'h1
`define RRS_OP_ROT_LEFT 3'h2
`define RRS_OP_ROT_RIGHT 3'h3
`define RRS_OP_SLEEP 3'h4

// ==========================================================================
// Status word fields and reset values
`define RRS_ST_C_BIT 0
`define RRS_ST_PWRDN_BIT 3
`define RRS_ST_TMOUT_BIT 4
`define RRS_C_RST 1'b0
`define RRS_PWRDN_RST 1'b1
`define RRS_TMOUT_RST 1'b1

// ==========================================================================
// Widths and layouts of other words
`define RRS_DATA_W 8
`define RRS_FA_W 7
`define RRS_FILE_DEPTH 128
`define RRS_PC_W 13
`define RRS_SP_W 3
`define RRS_STACK_DEPTH 8
`define RRS_STACK_SP_LSB 16
`define RRS_WDOG_W 8
`define RRS_WDOG_PRE_LSB 8
`define RRS_WAKE_BIT 0
`define RRS_SLEEP_BIT 0

`endif

// file: design/rrs_pkg.sv
/*
 * Types shared by the return/rotate/sleep execution block.
 * Assumes rrs_cfg.svh is available on the include path.
 */
`default_nettype none
`include "rrs_cfg.svh"

package rrs_pkg;
   typedef logic [`RRS_DATA_W-1:0] rrs_byte_t;
   typedef logic [`RRS_PC_W-1:0] rrs_pc_t;
   typedef logic [`RRS_SP_W-1:0] rrs_sp_t;
   typedef logic [`RRS_FA_W-1:0] rrs_fa_t;
   typedef logic [`RRS_WDOG_W-1:0] rrs_wdog_t;
   typedef logic [`RRS_OP_MSB-`RRS_OP_LSB:0] rrs_op_t;
   typedef enum logic [0:0] {ST_IDLE, ST_RET2} rrs_state_t;
endpackage

`default_nettype wire

// file: design/rrs_rotate.sv
/*
 * Rotate-through-carry unit, purely combinational.
 * Assumes the caller registers the result and the carry.
 */
`timescale 1ns/1ns
`default_nettype none

module rrs_rotate
   import rrs_pkg::*;
(
   input wire rrs_byte_t data_in,
   input wire logic carry_in,
   input wire logic left,
   output rrs_byte_t data_out,
   output logic carry_out
);

   // ========================================================================
   // Nine-bit ring of carry and data
   always_comb
   begin
      if (left)
      begin
         data_out = {data_in[`RRS_DATA_W-2:0], carry_in};
         carry_out = data_in[`RRS_DATA_W-1];
      end
      else
      begin
         data_out = {carry_in, data_in[`RRS_DATA_W-1:1]};
         carry_out = data_in[0];
      end
   end

endmodule

`default_nettype wire

// file: design/rrs_exec.sv
/*
 * Execution of return, rotate-left/right through carry and sleep for a small
 * 8-bit core, with W, file registers, carry and the two power flags, the
 * return stack, program counter and a watchdog count with prescaler.
 * Assumes an Avalon-MM master on clk; commands are written to the command
 * register, one at a time, and state is inspected through the other words.
 */
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "rrs_cfg.svh"

module rrs_exec
   import rrs_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [`RRS_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic osc_run
);

   // ========================================================================
   // Declarations
   rrs_state_t state_q;
   rrs_pc_t pc_q;
   rrs_pc_t ret_q;
   rrs_pc_t stack_q [`RRS_STACK_DEPTH];
   rrs_sp_t sp_q;
   rrs_byte_t w_q;
   rrs_byte_t file_q [`RRS_FILE_DEPTH];
   rrs_fa_t faddr_q;
   logic carry_q;
   logic timeout_flag_n_q;
   logic powerdown_flag_n_q;
   rrs_wdog_t watchdog_counter_q;
   rrs_wdog_t wdog_pre_q;
   logic sleep_q;
   logic rd_pend_q;
   logic [31:0] readdata_q;
   logic wr_acc;
   logic cmd_go;
   rrs_op_t op;
   logic dest_file;
   rrs_fa_t cmd_fa;
   logic is_rot;
   rrs_byte_t rot_res;
   logic rot_carry;
   rrs_pc_t stack_top_entry;

   function automatic logic hit(input logic [`RRS_ADDR_W-1:0] a, input logic [`RRS_ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   // ========================================================================
   // Bus handshake
   // Reads take one wait cycle so that read data come from a flip-flop
   assign waitrequest = !ce
      || (read && !rd_pend_q)
      || (write && hit(address, `RRS_OFF_CMD) && state_q != ST_IDLE);
   assign wr_acc = ce && write && !waitrequest;
   assign readdata = readdata_q;

   assign op = writedata[`RRS_OP_MSB:`RRS_OP_LSB];
   assign dest_file = writedata[`RRS_DEST_BIT];
   assign cmd_fa = writedata[`RRS_FA_MSB:`RRS_FA_LSB];
   // Commands written while asleep are answered but not executed
   assign cmd_go = wr_acc && hit(address, `RRS_OFF_CMD) && !sleep_q;
   assign is_rot = cmd_go && (op == `RRS_OP_ROT_LEFT || op == `RRS_OP_ROT_RIGHT);
   assign stack_top_entry = stack_q[sp_q - rrs_sp_t'(1)];
   assign osc_run = !sleep_q;

   rrs_rotate u_rot
   (
      .data_in(file_q[cmd_fa]),
      .carry_in(carry_q),
      .left(op == `RRS_OP_ROT_LEFT),
      .data_out(rot_res),
      .carry_out(rot_carry)
   );

   // ========================================================================
   // Read path
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rd_pend_q <= 1'b0;
         readdata_q <= 32'h0000_0000;
      end
      else if (ce)
      begin
         rd_pend_q <= read && !rd_pend_q;
         if (read && !rd_pend_q)
         begin
            readdata_q <= 32'h0000_0000;
            case (address)
               `RRS_OFF_WREG: readdata_q[`RRS_DATA_W-1:0] <= w_q;
               `RRS_OFF_STATUS:
               begin
                  readdata_q[`RRS_ST_C_BIT] <= carry_q;
                  readdata_q[`RRS_ST_PWRDN_BIT] <= powerdown_flag_n_q;
                  readdata_q[`RRS_ST_TMOUT_BIT] <= timeout_flag_n_q;
               end
               `RRS_OFF_PC: readdata_q[`RRS_PC_W-1:0] <= pc_q;
               `RRS_OFF_STACK:
               begin
                  readdata_q[`RRS_PC_W-1:0] <= stack_top_entry;
                  readdata_q[`RRS_STACK_SP_LSB +: `RRS_SP_W] <= sp_q;
               end
               `RRS_OFF_WDOG:
               begin
                  readdata_q[`RRS_WDOG_W-1:0] <= watchdog_counter_q;
                  readdata_q[`RRS_WDOG_PRE_LSB +: `RRS_WDOG_W] <= wdog_pre_q;
               end
               `RRS_OFF_FADDR: readdata_q[`RRS_FA_W-1:0] <= faddr_q;
               `RRS_OFF_FDATA: readdata_q[`RRS_DATA_W-1:0] <= file_q[faddr_q];
               `RRS_OFF_WAKE: readdata_q[`RRS_SLEEP_BIT] <= sleep_q;
               default: readdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ========================================================================
   // Sequencer and program counter
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         pc_q <= '0;
         ret_q <= '0;
      end
      else if (ce)
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (cmd_go && op == `RRS_OP_RETURN)
               begin
                  ret_q <= stack_top_entry;
                  state_q <= ST_RET2;
               end
               else if (cmd_go)
                  pc_q <= pc_q + rrs_pc_t'(1);
               else if (wr_acc && hit(address, `RRS_OFF_PC))
                  pc_q <= writedata[`RRS_PC_W-1:0];
            end
            ST_RET2:
            begin
               pc_q <= ret_q;
               state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ========================================================================
   // Return stack
   // Circular: popping an empty stack wraps, as pushing a full one does
   always_ff @(posedge clk)
   begin
      if (rst)
         sp_q <= '0;
      else if (ce)
      begin
         if (cmd_go && op == `RRS_OP_RETURN && state_q == ST_IDLE)
            sp_q <= sp_q - rrs_sp_t'(1);
         else if (wr_acc && hit(address, `RRS_OFF_STACK))
         begin
            stack_q[sp_q] <= writedata[`RRS_PC_W-1:0];
            sp_q <= sp_q + rrs_sp_t'(1);
         end
      end
   end

   // ========================================================================
   // Working register and file registers
   always_ff @(posedge clk)
   begin
      if (rst)
         w_q <= '0;
      else if (ce)
      begin
         if (is_rot && !dest_file)
            w_q <= rot_res;
         else if (wr_acc && hit(address, `RRS_OFF_WREG))
            w_q <= writedata[`RRS_DATA_W-1:0];
      end
   end

   // File array carries no reset; contents are undefined until written
   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         if (is_rot && dest_file)
            file_q[cmd_fa] <= rot_res;
         else if (wr_acc && hit(address, `RRS_OFF_FDATA))
            file_q[faddr_q] <= writedata[`RRS_DATA_W-1:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         faddr_q <= '0;
      else if (ce && wr_acc && hit(address, `RRS_OFF_FADDR))
         faddr_q <= writedata[`RRS_FA_W-1:0];
   end

   // ========================================================================
   // Status flags
   // Return leaves every flag alone; rotates touch carry only
   always_ff @(posedge clk)
   begin
      if (rst)
         carry_q <= `RRS_C_RST;
      else if (ce)
      begin
         if (is_rot)
            carry_q <= rot_carry;
         else if (wr_acc && hit(address, `RRS_OFF_STATUS))
            carry_q <= writedata[`RRS_ST_C_BIT];
      end
   end

   // Power flags are read-only to software; only reset and sleep move them
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         timeout_flag_n_q <= `RRS_TMOUT_RST;
         powerdown_flag_n_q <= `RRS_PWRDN_RST;
      end
      else if (ce && cmd_go && op == `RRS_OP_SLEEP)
      begin
         timeout_flag_n_q <= 1'b1;
         powerdown_flag_n_q <= 1'b0;
      end
   end

   // ========================================================================
   // Watchdog count with prescaler, cleared on sleep
   // Counting stands in for the real time base and stops with the oscillator
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         watchdog_counter_q <= '0;
         wdog_pre_q <= '0;
      end
      else if (ce)
      begin
         if (cmd_go && op == `RRS_OP_SLEEP)
         begin
            watchdog_counter_q <= '0;
            wdog_pre_q <= '0;
         end
         else if (!sleep_q)
         begin
            wdog_pre_q <= wdog_pre_q + rrs_wdog_t'(1);
            if (wdog_pre_q == '1)
               watchdog_counter_q <= watchdog_counter_q + rrs_wdog_t'(1);
         end
      end
   end

   // ========================================================================
   // Sleep state; a wake write is the only way out besides reset
   always_ff @(posedge clk)
   begin
      if (rst)
         sleep_q <= 1'b0;
      else if (ce)
      begin
         if (cmd_go && op == `RRS_OP_SLEEP)
            sleep_q <= 1'b1;
         else if (wr_acc && hit(address, `RRS_OFF_WAKE) && writedata[`RRS_WAKE_BIT])
            sleep_q <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// file: verif/rrs_exec_properties.sv
/* Port checker for rrs_exec.
   Assumes one clock and a synchronous reset; bound to every rrs_exec. */
`timescale 1ns/1ns
`default_nettype none
`include "rrs_cfg.svh"
module rrs_exec_properties
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [`RRS_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic osc_run
);
   // ========
   // Taken requests
   logic cmd_ok;
   logic rd_ok;
   logic wake_ok;
   assign cmd_ok = write && !waitrequest && ce && address == `RRS_OFF_CMD;
   assign rd_ok = read && !waitrequest && ce;
   assign wake_ok = write && !waitrequest && address == `RRS_OFF_WAKE && writedata[`RRS_WAKE_BIT];
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_ce_stalls: assert property (!ce |-> waitrequest) else $error("stall ignored");
   a_read_wait: assert property ($rose(read) && ce |-> waitrequest) else $error("read early");
   a_ret_blocks_cmd: assert property (cmd_ok && osc_run && writedata[2:0] == `RRS_OP_RETURN ##1
      (write && address == `RRS_OFF_CMD) |-> waitrequest) else $error("return too short");
   a_ret_two_cycles: assert property (cmd_ok && writedata[2:0] == `RRS_OP_RETURN ##1 ce ##1
      (write && ce && address == `RRS_OFF_CMD) |-> !waitrequest) else $error("return too long");
   a_rot_one_cycle: assert property (cmd_ok && osc_run && (writedata[2:0] == `RRS_OP_ROT_LEFT
      || writedata[2:0] == `RRS_OP_ROT_RIGHT) ##1 (write && ce && address == `RRS_OFF_CMD) |-> !waitrequest)
      else $error("rotate stalls");
   a_sleep_stops: assert property (cmd_ok && osc_run && writedata[2:0] == `RRS_OP_SLEEP |=> !osc_run)
      else $error("sleep ignored");
   a_sleep_holds: assert property (!osc_run && !wake_ok |=> !osc_run) else $error("woke alone");
   a_wake_runs: assert property (!osc_run && wake_ok |=> osc_run) else $error("wake ignored");
   a_wdog_cleared: assert property (rd_ok && address == `RRS_OFF_WDOG && !osc_run |-> readdata == 0)
      else $error("watchdog not clear");
   a_sleep_flags: assert property (rd_ok && address == `RRS_OFF_STATUS && !osc_run
      |-> readdata[4:3] == 2'b10) else $error("sleep flags wrong");
   c_return: cover property (cmd_ok && writedata[2:0] == `RRS_OP_RETURN);
   c_sleep: cover property (cmd_ok && writedata[2:0] == `RRS_OP_SLEEP);
   c_asleep_read: cover property (rd_ok && !osc_run);
endmodule

bind rrs_exec rrs_exec_properties rrs_exec_properties_i (.clk(clk), .rst(rst), .ce(ce), .address(address),
   .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
   .osc_run(osc_run));
`default_nettype wire

// file: verif/rrs_exec_tb.sv
/* Self-checking bench for rrs_exec: random rotates, return, sleep.
   Acts as Avalon-MM master itself; the checker is bound separately. */
`timescale 1ns/1ns
`default_nettype none
`include "rrs_cfg.svh"
module rrs_exec_tb;
   logic clk, rst, ce, read, write, osc_run, waitrequest;
   logic [`RRS_ADDR_W-1:0] address;
   logic [31:0] writedata, readdata, v, x;
   logic [12:0] pc, e1, e2;
   logic [8:0] r;
   integer seed = 88249, n_mismatch = 0, checks = 0, cyc = 0;
   rrs_exec rrs_exec_i (.clk(clk), .rst(rst), .ce(ce), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .osc_run(osc_run));
   // ========
   // Helpers
   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         n_mismatch++;
         final_report;
      end
   end
   task final_report;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: %h not %h", $time, seen, exp);
      end
   endtask
   // Hold keeps write up so the next call can follow back to back
   task wr(logic [`RRS_ADDR_W-1:0] a, logic [31:0] d, bit hold = 0);
      address <= a;
      writedata <= d;
      write <= 1;
      @(posedge clk);
      while (waitrequest !== 0)
         @(posedge clk);
      if (!hold)
      begin
         write <= 0;
         @(posedge clk);
      end
   endtask
   task rd(logic [`RRS_ADDR_W-1:0] a);
      address <= a;
      read <= 1;
      @(posedge clk);
      while (waitrequest !== 0)
         @(posedge clk);
      v = readdata;
      read <= 0;
      @(posedge clk);
   endtask
   function automatic logic [8:0] rot(logic [7:0] d, logic c, logic l);
      return l ? {d, c} : {d[0], c, d[7:1]};
   endfunction
   // ========
   // Main sequence
   initial
   begin
      rst = 1;
      ce = 1;
      read = 0;
      write = 0;
      address = 0;
      writedata = 0;
      repeat (16) @(posedge clk);
      rst <= 0;
      rd(`RRS_OFF_STATUS);
      chk(v, 32'h18);
      ce <= 0;
      repeat (3) @(posedge clk);
      ce <= 1;
      x = $random(seed);
      pc = x[12:0];
      wr(`RRS_OFF_PC, {19'h0, pc});
      // x: file addr, data, W, carry, left, dest
      for (int i = 0; i < 24; i++)
      begin
         x = $random(seed);
         if (i == 0)
            x = 32'h0200e600;
         wr(`RRS_OFF_FADDR, {25'h0, x[6:0]});
         wr(`RRS_OFF_FDATA, {24'h0, x[15:8]});
         wr(`RRS_OFF_WREG, {24'h0, x[23:16]});
         wr(`RRS_OFF_STATUS, {31'h0, x[24]});
         // Odd passes follow the rotate at once with a nop
         wr(`RRS_OFF_CMD, {17'h0, x[6:0], x[26], 4'h0, x[25] ? `RRS_OP_ROT_LEFT : `RRS_OP_ROT_RIGHT}, i[0]);
         if (i[0])
            wr(`RRS_OFF_CMD, {29'h0, `RRS_OP_NOP});
         r = rot(x[15:8], x[24], x[25]);
         pc = pc + (i[0] ? 13'h2 : 13'h1);
         rd(`RRS_OFF_WREG);
         chk(v, {24'h0, x[26] ? x[23:16] : r[7:0]});
         rd(`RRS_OFF_FDATA);
         chk(v, {24'h0, x[26] ? r[7:0] : x[15:8]});
         rd(`RRS_OFF_STATUS);
         chk(v, {27'h0, 4'hc, r[8]});
         rd(`RRS_OFF_PC);
         chk(v, {19'h0, pc});
      end
      $display("test done: rotate");
      x = $random(seed);
      e1 = x[12:0];
      e2 = x[28:16];
      wr(`RRS_OFF_STACK, {19'h0, e1});
      wr(`RRS_OFF_STACK, {19'h0, e2});
      rd(`RRS_OFF_STACK);
      chk(v, {13'h0, 3'h2, 3'h0, e2});
      wr(`RRS_OFF_CMD, {29'h0, `RRS_OP_RETURN}, 1);
      wr(`RRS_OFF_CMD, {29'h0, `RRS_OP_NOP});
      pc = e2 + 13'h1;
      rd(`RRS_OFF_PC);
      chk(v, {19'h0, pc});
      rd(`RRS_OFF_STACK);
      chk(v, {13'h0, 3'h1, 3'h0, e1});
      rd(`RRS_OFF_STATUS);
      chk(v, {27'h0, 4'hc, r[8]});
      $display("test done: return");
      wr(`RRS_OFF_CMD, {29'h0, `RRS_OP_SLEEP});
      pc++;
      chk(osc_run, 0);
      rd(`RRS_OFF_STATUS);
      chk(v, {27'h0, 4'h8, r[8]});
      rd(`RRS_OFF_WDOG);
      chk(v, 0);
      rd(`RRS_OFF_WAKE);
      chk(v, 32'h1);
      // Commands while asleep must not execute
      wr(`RRS_OFF_CMD, {29'h0, `RRS_OP_ROT_LEFT});
      rd(`RRS_OFF_PC);
      chk(v, {19'h0, pc});
      wr(`RRS_OFF_WAKE, 32'h1);
      chk(osc_run, 1);
      $display("test done: sleep");
      final_report;
   end
endmodule
`default_nettype wire
